// ==== rtl/ats_pkg.sv ====
// package of the adc threshold status block: register map, field layout, types
// assumes a 10-bit sample code and a 24-input switch front end
package ats_pkg;
  // ----------------------------------------------------------------
  // register map (index times four gives the byte address)
  // ----------------------------------------------------------------
  localparam logic [7:0] ATS_IDX_STATUS_LOW = 8'h06;  // adc_band_status_low index
  localparam logic [7:0] ATS_IDX_STATUS_HIGH = 8'h07;  // adc_band_status_high index
  localparam logic [7:0] ATS_ADDR_STATUS_LOW = 8'h18;  // byte address, four times index
  localparam logic [7:0] ATS_ADDR_STATUS_HIGH = 8'h1C;  // byte address, four times index
  localparam logic [23:0] ATS_STATUS_RESET = 24'h000000;  // both registers clear at reset
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int ATS_NUM_INPUTS = 24;  // switch inputs
  localparam int ATS_FLAG_LAST = 11;  // last single-threshold input
  localparam int ATS_BAND_FIRST = 18;  // first two-bit band input
  localparam int ATS_BAND_LAST = 22;  // last two-bit band input
  localparam logic [4:0] ATS_WIDE_INPUT = 5'h17;  // input with five thresholds
  localparam int ATS_WIDE_LSB = 10;  // lsb of its three-bit field
  localparam logic [2:0] ATS_BAND_FOURTH = 3'h3;  // at or above c, below fourth limit
  localparam logic [2:0] ATS_BAND_FIFTH_LOW = 3'h4;  // at or above fourth, below fifth
  localparam logic [2:0] ATS_BAND_TOP = 3'h5;  // at or above the fifth limit
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;  // one-cycle strobe
    logic [4:0] chan;  // input number
    logic [9:0] code;  // converted level
  } ats_sample_t;
  typedef struct packed {
    logic [9:0] single;  // limit for inputs 0 to 11
    logic [9:0] lim_a;  // first band limit
    logic [9:0] lim_b;  // second band limit
    logic [9:0] lim_c;  // third band limit
    logic [9:0] fourth_band_limit;  // fourth limit, input 23 only
    logic [9:0] fifth_band_limit;  // fifth limit, input 23 only
  } ats_limits_t;
endpackage

// ==== rtl/ats_status.sv ====
// adc threshold status registers with an avalon-mm slave port
// assumes samples and limits come from logic on ref_clk_i
//
// Contract
// - inputs 0-11 report one above/below bit
// - inputs 18-22 report two-bit band code
// - band codes in pairs 1-0 through 9-8
// - input 23 three-bit code, 5 top
// - input 23 codes 3 and 4 bands
// - bands evaluated only in adc mode
// - high register offset 7, zero after reset
`timescale 1ns/1ps
`default_nettype none
module ats_status
  import ats_pkg::*;
(
  input wire logic ref_clk_i,  // 10 MHz clock
  input wire logic reset_n_i,  // async reset, active low
  input wire ats_sample_t sample_i,  // converted sample with strobe
  input wire ats_limits_t limits_i,  // programmed limits
  input wire logic [23:0] adc_mode_i,  // per input: adc input mode
  input wire logic [7:0] avs_address,  // byte address
  input wire logic avs_read,  // read request
  input wire logic avs_write,  // write request, acknowledged but changes nothing
  input wire logic [31:0] avs_writedata,  // write data, ignored
  input wire logic [3:0] avs_byteenable,  // byte enables, ignored
  output logic [31:0] avs_readdata,  // read data, registered
  output logic avs_waitrequest  // stall until answer ready
);
  // ----------------------------------------------------------------
  // band evaluation
  // ----------------------------------------------------------------
  // three-limit band: 0 below a, 1 a..b, 2 b..c, 3 at or above c
  // priority runs from the highest limit down, so equal limits collapse a band
  // rather than produce a code that skips one; the limits are taken as ordered
  function automatic logic [1:0] band3(input logic [9:0] v, input ats_limits_t l);
    if (v >= l.lim_c) begin
      band3 = 2'h3;
    end else if (v >= l.lim_b) begin
      band3 = 2'h2;
    end else if (v >= l.lim_a) begin
      band3 = 2'h1;
    end else begin
      band3 = 2'h0;
    end
  endfunction

  // five-limit band for input 23
  // codes 0 to 2 reuse the three-limit bands; 3, 4 and 5 split the region above c
  function automatic logic [2:0] band5(input logic [9:0] v, input ats_limits_t l);
    if (v >= l.fifth_band_limit) begin
      band5 = ATS_BAND_TOP;
    end else if (v >= l.fourth_band_limit) begin
      band5 = ATS_BAND_FIFTH_LOW;
    end else if (v >= l.lim_c) begin
      band5 = ATS_BAND_FOURTH;
    end else begin
      band5 = {1'b0, band3(v, l)};
    end
  endfunction

  // ----------------------------------------------------------------
  // status storage and update
  // ----------------------------------------------------------------
  logic [23:0] status_low;  // adc_band_status_low
  logic [23:0] status_high;  // adc_band_status_high
  logic [23:0] next_status_low;  // low register after this sample
  logic [23:0] next_status_high;  // high register after this sample
  // a strobe for an input outside adc mode, or with no field here, is dropped
  wire logic sample_take = sample_i.valid && adc_mode_i[sample_i.chan];
  wire logic above_single = (sample_i.code >= limits_i.single);  // single-limit compare
  wire logic [1:0] band_code = band3(sample_i.code, limits_i);
  wire logic [2:0] wide_code = band5(sample_i.code, limits_i);

  // per-field next values; fields 12-17 and 23-13 stay zero
  // each field is written only by a strobe for its own input, so a strobe
  // for another input leaves it untouched
  genvar gi;
  generate
    for (gi = 0; gi < ATS_NUM_INPUTS; gi++) begin : g_field
      if (gi <= ATS_FLAG_LAST) begin : g_flag
        assign next_status_low[gi] = (sample_take && sample_i.chan == 5'(gi)) ?
            above_single : status_low[gi];
      end else begin : g_zero
        assign next_status_low[gi] = 1'b0;  // low-register bits 12-23 not held here
      end
      if (gi >= ATS_BAND_FIRST && gi <= ATS_BAND_LAST) begin : g_band
        localparam int LSB = 2 * (gi - ATS_BAND_FIRST);
        assign next_status_high[LSB+1:LSB] = (sample_take && sample_i.chan == 5'(gi)) ?
            band_code : status_high[LSB+1:LSB];
      end
    end
  endgenerate
  assign next_status_high[12:10] = (sample_take && sample_i.chan == ATS_WIDE_INPUT) ?
      wide_code : status_high[12:10];
  assign next_status_high[23:13] = 11'h000;

  // status registers clear at reset and follow samples only
  // no write path reaches these registers; the bus side only reads them
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_low <= ATS_STATUS_RESET;
      status_high <= ATS_STATUS_RESET;
    end else begin
      status_low <= next_status_low;
      status_high <= next_status_high;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  // writes are acknowledged like reads but change nothing; write data and
  // byte enables are left unread on purpose
  logic bus_ack;  // high in the answer cycle
  logic [31:0] next_readdata;  // decoded read value
  wire logic bus_req = avs_read || avs_write;  // any request
  wire logic hit_low = (avs_address == ATS_ADDR_STATUS_LOW);  // low register decode
  wire logic hit_high = (avs_address == ATS_ADDR_STATUS_HIGH);
  assign next_readdata = hit_high ? {8'h00, status_high} :
      (hit_low ? {8'h00, status_low} : 32'h00000000);  // unmapped reads zero
  assign avs_waitrequest = bus_req && !bus_ack;

  // acknowledge toggles so each request takes exactly two cycles
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  // read data captured in the wait cycle, standing in the answer cycle
  // holding the word outside the capture keeps it steady through the answer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // all checks run on ref_clk_i and rest while reset is low, except the reset one
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_take(logic [4:0] ch);
    sample_i.valid && adc_mode_i[ch] && sample_i.chan == ch;
  endsequence

  AST_FLAG: assert property (s_take(5'h05) |=>
      status_low[5] == ($past(sample_i.code) >= $past(limits_i.single)))
    else $error("single-limit flag wrong");
  AST_BAND18: assert property (s_take(5'h12) ##0 (sample_i.code < limits_i.lim_a) |=>
      status_high[1:0] == 2'h0)
    else $error("band code of input 18 wrong");
  AST_PAIR20: assert property (s_take(5'h14) ##0 (sample_i.code >= limits_i.lim_c) |=>
      status_high[5:4] == 2'h3 && $stable(status_high[3:0]) && $stable(status_high[9:6]))
    else $error("band pair of input 20 misplaced");
  AST_TOP23: assert property (s_take(ATS_WIDE_INPUT) ##0
      (sample_i.code >= limits_i.fifth_band_limit) |=> status_high[12:10] == 3'h5)
    else $error("top band of input 23 wrong");
  AST_MID23: assert property (s_take(ATS_WIDE_INPUT) ##0 (sample_i.code >= limits_i.lim_c)
      ##0 (sample_i.code < limits_i.fourth_band_limit)
      ##0 (limits_i.fourth_band_limit <= limits_i.fifth_band_limit)
      |=> status_high[12:10] == 3'h3)
    else $error("band three of input 23 wrong");
  AST_MODE: assert property (sample_i.valid && !adc_mode_i[sample_i.chan] |=>
      $stable(status_low) && $stable(status_high))
    else $error("status moved outside adc mode");
  // the default disable would silence this check for its whole antecedent
  AST_RESET: assert property (@(posedge ref_clk_i) disable iff (1'b0) !reset_n_i |->
      status_high == 24'h000000 && status_low == 24'h000000)
    else $error("status not clear in reset");
  AST_RO: assert property (avs_write && !sample_i.valid |=>
      $stable(status_high) && status_high[23:13] == 11'h000)
    else $error("write changed status");
  AST_READ: assert property (avs_read && !avs_waitrequest && $past(avs_read) |->
      avs_readdata[31:24] == 8'h00 && avs_readdata[23:13] == 11'h000 || !hit_high)
    else $error("high register read upper bits not zero");

  // ----------------------------------------------------------------
  // bus handshake checks
  // ----------------------------------------------------------------
  // a fresh request, stalled in its first cycle
  sequence s_bus_first;
    (avs_read || avs_write) && !bus_ack && avs_waitrequest;
  endsequence

  // the answer cycle: request still up, stall dropped
  sequence s_bus_answer;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence

  // a read of the high register, capture cycle then answer cycle
  sequence s_read_high;
    avs_read && hit_high && !bus_ack ##1 avs_read && !avs_waitrequest;
  endsequence

  // the same two cycles for the low register
  sequence s_read_low;
    avs_read && hit_low && !bus_ack ##1 avs_read && !avs_waitrequest;
  endsequence

  AST_ONE_WAIT: assert property (s_bus_first ##1 (avs_read || avs_write) |->
      s_bus_answer)
    else $error("bus answer not after one wait cycle");
  AST_HIGH_WORD: assert property (s_read_high |->
      avs_readdata == {8'h00, $past(status_high)})
    else $error("high register read returned wrong word");
  AST_LOW_WORD: assert property (s_read_low |->
      avs_readdata == {8'h00, $past(status_low)})
    else $error("low register read returned wrong word");
  AST_WRITE_QUIET: assert property (avs_write && !avs_read |=>
      $stable(avs_readdata))
    else $error("write disturbed read data");
  AST_LOW_UPPER: assert property (status_low[23:12] == 12'h000)
    else $error("unused low register bits set");
endmodule
`default_nettype wire

// ==== test/ats_host_model.sv ====
// host model: avalon-mm master standing in for the status reader
// assumes a slave that stalls with waitrequest, sampled at each rising edge
`timescale 1ns/1ps
`default_nettype none
module ats_host_model (
  input wire logic clk_i,  // bench clock
  input wire logic waitrequest_i,  // slave stall
  output logic [7:0] address_o,  // byte address
  output logic read_o,  // read request
  output logic write_o,  // write request
  output logic [31:0] writedata_o  // write data
);
  initial begin
    address_o <= 8'h00;
    read_o <= 1'b0;
    write_o <= 1'b0;
    writedata_o <= 32'h00000000;
  end
  // one transfer, entered just after a rising edge; ok low on timeout
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic ok);
    ok = 1'b0;
    address_o <= a;
    writedata_o <= d;
    read_o <= !wr;
    write_o <= wr;
    // waitrequest is read at each rising edge, before that edge's updates land
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_i);
      ok = (waitrequest_i === 1'b0);
    end
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/ats_status_tb.sv ====
// testbench of the threshold status block: random samples, band edges, reads
// assumes the design stalls each bus request with waitrequest
`timescale 1ns/1ps
`default_nettype none
module ats_status_tb;
  import ats_pkg::*;
  logic ref_clk_i;
  logic reset_n_i;
  ats_sample_t smp;
  ats_limits_t lim;
  logic [23:0] mode;
  logic [7:0] adr;
  logic rd, wr, wreq, ok;
  logic [31:0] wd, rdat, e;
  logic [23:0] exp_lo, exp_hi;
  logic [31:0] exp_q[$];
  logic [9:0] edges [6] = '{10'h0FF, 10'h100, 10'h200, 10'h300, 10'h380, 10'h3C0};
  int num_errors, checked, seed;
  ats_status u_ats_status (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sample_i(smp),
    .limits_i(lim), .adc_mode_i(mode), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq));
  ats_host_model u_ats_host_model (.clk_i(ref_clk_i), .waitrequest_i(wreq), .address_o(adr),
    .read_o(rd), .write_o(wr), .writedata_o(wd));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // band of a level against the ordered limits, highest first
  function automatic logic [2:0] bnd(logic [9:0] c);
    return c >= lim.fifth_band_limit ? 3'h5 : c >= lim.fourth_band_limit ? 3'h4 :
      c >= lim.lim_c ? 3'h3 : c >= lim.lim_b ? 3'h2 : c >= lim.lim_a ? 3'h1 : 3'h0;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bus access; a read notes its expected word first
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    u_ats_host_model.xfer(w, a, d, ok);
    if (!ok) begin
      $display("[FAIL] waitrequest at %h expected 0 seen 1", a);
      num_errors++;
      finish_test();
    end
    @(posedge ref_clk_i);
  endtask
  // one sample strobe; the model fields follow only for adc-mode inputs
  task automatic put(input logic [4:0] ch, input logic [9:0] cd);
    logic [2:0] b;
    b = bnd(cd);
    smp <= '{1'b1, ch, cd};
    if (ch <= 5'd11 && mode[ch]) exp_lo[ch] = cd >= lim.single;
    if (ch >= 5'd18 && ch <= 5'd22 && mode[ch])
      exp_hi[2*(ch-5'd18) +: 2] = b > 3 ? 2'h3 : b[1:0];
    if (ch == ATS_WIDE_INPUT && mode[ch]) exp_hi[12:10] = b;
    @(posedge ref_clk_i);
  endtask
  // result watcher: at the edge where a read sees waitrequest low, the word
  // standing on readdata is compared with the oldest note
  always @(posedge ref_clk_i) begin
    if (rd === 1'b1 && wreq === 1'b0) begin
      e = exp_q.pop_front();
      checked++;
      if (rdat !== e) begin
        num_errors++;
        $display("[FAIL] readdata at %h expected %h seen %h", adr, e, rdat);
      end
    end
  end
  initial begin
    seed = 1190;
    num_errors = 0;
    checked = 0;
    reset_n_i = 1'b0;
    smp = '0;
    mode = '0;
    exp_lo = '0;
    exp_hi = '0;
    lim = '{10'h200, 10'h100, 10'h200, 10'h300, 10'h380, 10'h3C0};
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    acc(1'b0, ATS_ADDR_STATUS_HIGH, 32'h00000000);
    acc(1'b0, ATS_ADDR_STATUS_LOW, 32'h00000000);
    $display("test reset values done");
    for (int r = 0; r < 5; r++) begin
      mode <= 24'($random(seed));
      @(posedge ref_clk_i);
      repeat (40) put(5'($random(seed)), 10'($random(seed)));
      smp.valid <= 1'b0;
      acc(1'b1, ATS_ADDR_STATUS_HIGH, $random(seed));
      acc(1'b1, ATS_ADDR_STATUS_LOW, $random(seed));
      acc(1'b0, ATS_ADDR_STATUS_LOW, {8'h00, exp_lo});
      acc(1'b0, ATS_ADDR_STATUS_HIGH, {8'h00, exp_hi});
      $display("test random round %0d done", r);
    end
    mode <= 24'hFFFFFF;
    @(posedge ref_clk_i);
    foreach (edges[k]) begin
      put(ATS_WIDE_INPUT, edges[k]);
      put(5'd22, edges[k]);
      smp.valid <= 1'b0;
      acc(1'b0, ATS_ADDR_STATUS_HIGH, {8'h00, exp_hi});
    end
    acc(1'b0, 8'h04, 32'h00000000);
    $display("test band edges done");
    // second reset in mid-run: both registers must read clear again
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    exp_lo = '0;
    exp_hi = '0;
    @(posedge ref_clk_i);
    acc(1'b0, ATS_ADDR_STATUS_HIGH, 32'h00000000);
    acc(1'b0, ATS_ADDR_STATUS_LOW, 32'h00000000);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
`default_nettype wire
